// ---- include/video_cfg_pkg.sv ----
// register map, field layout and reset values of the black-level and sync control bank
package video_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] OFF_MODE_CFG = 8'h05;
    localparam logic [7:0] OFF_RED_TGT = 8'h1d;
    localparam logic [7:0] OFF_GREEN_TGT = 8'h1e;
    localparam logic [7:0] OFF_BLUE_TGT = 8'h1f;
    localparam logic [7:0] OFF_CLAMP = 8'h23;
    localparam logic [7:0] OFF_SYNC_CTRL = 8'h25;
    localparam logic [7:0] OFF_REF_MULT = 8'h2b;
    localparam logic [7:0] OFF_RED_DOFS = 8'h38;
    localparam logic [7:0] OFF_GREEN_DOFS = 8'h39;
    localparam logic [7:0] OFF_BLUE_DOFS = 8'h3a;
    localparam logic [7:0] OFF_PHASE = 8'h3b;
    localparam logic [7:0] OFF_STATUS = 8'h3c;
    // reset values; reserved bits carry their required values here
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_CLAMP = 8'h18;
    localparam logic [7:0] RST_SYNC = 8'h00;
    localparam logic [7:0] RST_REF_MULT = 8'h14;
    localparam logic [7:0] RST_DOFS = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h00;
    // bits that software may change; the rest keep their reset value
    localparam logic [7:0] WMASK_MODE = 8'h04;
    localparam logic [7:0] WMASK_CLAMP = 8'h70;
    localparam logic [7:0] WMASK_SYNC = 8'h97;
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam logic [7:0] WMASK_PHASE = 8'h3f;
    localparam logic [3:0] CLAMP_RSVD_VAL = 4'h8;
    // field positions
    localparam int MODE_YCBCR_BIT = 2;
    localparam int CLAMP_SEL_LSB = 4;
    localparam int CLAMP_SEL_MSB = 6;
    localparam int SYNC_TRISTATE_BIT = 0;
    localparam int SYNC_COAST_POL_BIT = 1;
    localparam int SYNC_LEAD_LOCK_BIT = 2;
    localparam int SYNC_VRAW_BIT = 4;
    localparam int SYNC_VCOAST_BIT = 7;
    localparam logic [2:0] CLAMP_OFF = 3'h0;
    // sampling phase and line timing
    localparam int PHASE_W = 6;
    localparam int PHASE_STEPS = 64;
    localparam int HPULSE_WIDTH_DEF = 16;
    localparam int LINE_CNT_W_DEF = 12;
    localparam int NCO_W_DEF = 24;
    localparam int NUM_CH = 3;
    localparam logic [7:0] MID_SCALE = 8'h80;
    localparam logic [7:0] ZERO_CODE = 8'h00;
endpackage : video_cfg_pkg

// ---- hdl/channel_black_servo.sv ----
// one channel: black-level target, servo direction and digital offset adder
`timescale 1ns/100ps
`default_nettype none
module channel_black_servo #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] targetCode,
    input wire logic midScale,
    input wire logic [W-1:0] digitalOffset,
    input wire logic [W-1:0] sample,
    input wire logic backPorch,
    output var logic [W-1:0] blackLevel_q,
    output var logic servoUp_q,
    output var logic servoDown_q,
    output var logic [W-1:0] adjustedSample_q
);
    localparam logic [W-1:0] MID = {1'b1, {(W-1){1'b0}}};
    localparam logic [W-1:0] TOP = {W{1'b1}};

    logic [W-1:0] blackLevel_d;
    logic servoUp_d;
    logic servoDown_d;
    logic [W-1:0] adjustedSample_d;

    // unsigned base plus signed code, clipped to the converter range
    function automatic logic [W-1:0] sat_add(input logic [W-1:0] base,
                                             input logic [W-1:0] code);
        logic signed [W+1:0] s;
        s = $signed({2'b00, base}) + $signed({{2{code[W-1]}}, code});
        if (s < 0) sat_add = '0;
        else if (s > $signed({2'b00, TOP})) sat_add = TOP;
        else sat_add = s[W-1:0];
    endfunction : sat_add

    // target is independent of the offset adder, both act at once
    always_comb begin
        blackLevel_d = sat_add(midScale ? MID : '0, targetCode); // RL1 RL2 RL3
        servoUp_d = backPorch && (sample < blackLevel_q);
        servoDown_d = backPorch && (sample > blackLevel_q);
        adjustedSample_d = sat_add(sample, digitalOffset); // RL4
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blackLevel_q <= '0;
            servoUp_q <= 1'b0;
            servoDown_q <= 1'b0;
            adjustedSample_q <= '0;
        end else if (ce) begin
            blackLevel_q <= blackLevel_d;
            servoUp_q <= servoUp_d;
            servoDown_q <= servoDown_d;
            adjustedSample_q <= adjustedSample_d;
        end
    end
endmodule : channel_black_servo
`default_nettype wire

// ---- hdl/black_level_target_sync_output_ctrl.sv ----
// black-level targets, clamp strength, sync output control and sampling phase registers
// What this block does
// RL1: red target signed; mid-scale base in YPbPr
// RL2: green target always from zero base
// RL3: blue target signed; mid-scale base in YPbPr
// RL4: target and digital offset adder both apply
// RL5: shared 3-bit clamp strength, zero disconnects
// RL6: disable bit releases all four sync pins
// RL7: coast polarity bit inverts coast input
// RL8: software keeps polarity zero for internal sync
// RL9: lock bit zero pins trailing horizontal edge
// RL10: lock bit one pins leading horizontal edge
// RL11: vertical output aligned or raw integrator
// RL12: select bit routes coast onto vertical pin
// RL13: software raises multiplier for fastest grade
// RL14: sixty-four sampling phase steps per pixel
// RL15: oscillator runs from crystal clock only
// RL16: software programs only pixels per line; no such register here, line length is learnt between lock strobes
// RL17: mode bit selects YPbPr mid-scale processing
// RL18: eight-bit registers, reset defaults, reserved fixed
`timescale 1ns/100ps
`default_nettype none
module black_level_target_sync_output_ctrl #(
    parameter int HPULSE_WIDTH = video_cfg_pkg::HPULSE_WIDTH_DEF,
    parameter int LINE_CNT_W = video_cfg_pkg::LINE_CNT_W_DEF,
    parameter int NCO_W = video_cfg_pkg::NCO_W_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [video_cfg_pkg::ADDR_W-1:0] regAddr,
    input wire logic [video_cfg_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [video_cfg_pkg::DATA_W-1:0] regRdData,
    input wire logic [7:0] redSample,
    input wire logic [7:0] greenSample,
    input wire logic [7:0] blueSample,
    input wire logic backPorch,
    output logic [7:0] redBlackLevel,
    output logic [7:0] greenBlackLevel,
    output logic [7:0] blueBlackLevel,
    output logic [7:0] redAdjusted,
    output logic [7:0] greenAdjusted,
    output logic [7:0] blueAdjusted,
    output logic [video_cfg_pkg::NUM_CH-1:0] servoUp,
    output logic [video_cfg_pkg::NUM_CH-1:0] servoDown,
    output logic [2:0] clampSelect,
    output logic clampEnable,
    output logic ycbcrMode,
    input wire logic lockEdgeStrobe,
    input wire logic horizSyncInput,
    input wire logic rawVertSync,
    input wire logic coastIn,
    output logic coastActive,
    output logic horizPulseOut,
    output logic horizPulseOe,
    output logic vertPulseOut,
    output logic vertPulseOe,
    output logic horizSyncPassthruOut,
    output logic horizSyncPassthruOe,
    output logic separatedVertSyncOut,
    output logic separatedVertSyncOe,
    output logic [7:0] referenceMultiplier,
    input wire logic [NCO_W-1:0] ncoStep,
    output logic [video_cfg_pkg::PHASE_W-1:0] samplePhase
);
    localparam logic [LINE_CNT_W-1:0] WIDTH_C = LINE_CNT_W'(HPULSE_WIDTH);
    localparam logic [LINE_CNT_W-1:0] LINE_MAX = {LINE_CNT_W{1'b1}};
    localparam int PW = video_cfg_pkg::PHASE_W;

    // register bank state
    logic [7:0] modeCfg_q, modeCfg_d;
    logic [7:0] tgt_q [video_cfg_pkg::NUM_CH];
    logic [7:0] tgt_d [video_cfg_pkg::NUM_CH];
    logic [7:0] dofs_q [video_cfg_pkg::NUM_CH];
    logic [7:0] dofs_d [video_cfg_pkg::NUM_CH];
    logic [7:0] clamp_q, clamp_d;
    logic [7:0] syncCtrl_q, syncCtrl_d;
    logic [7:0] refMult_q, refMult_d;
    logic [7:0] phaseReg_q, phaseReg_d;
    logic [7:0] rdData_q, rdData_d;
    logic rdValid_q;

    // reserved bits are never written, so they keep their required values
    function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] mask,
                                         input logic [7:0] fixed);
        merge = (wd & mask) | (fixed & ~mask);
    endfunction : merge

    // register writes
    always_comb begin
        modeCfg_d = modeCfg_q;
        tgt_d = tgt_q;
        dofs_d = dofs_q;
        clamp_d = clamp_q;
        syncCtrl_d = syncCtrl_q;
        refMult_d = refMult_q;
        phaseReg_d = phaseReg_q;
        if (regWrite) begin
            case (regAddr)
                video_cfg_pkg::OFF_MODE_CFG: modeCfg_d = merge(regWrData,
                    video_cfg_pkg::WMASK_MODE, video_cfg_pkg::RST_MODE); // RL17
                video_cfg_pkg::OFF_RED_TGT: tgt_d[0] = regWrData; // RL18
                video_cfg_pkg::OFF_GREEN_TGT: tgt_d[1] = regWrData;
                video_cfg_pkg::OFF_BLUE_TGT: tgt_d[2] = regWrData;
                video_cfg_pkg::OFF_RED_DOFS: dofs_d[0] = regWrData;
                video_cfg_pkg::OFF_GREEN_DOFS: dofs_d[1] = regWrData;
                video_cfg_pkg::OFF_BLUE_DOFS: dofs_d[2] = regWrData;
                video_cfg_pkg::OFF_CLAMP: clamp_d = merge(regWrData,
                    video_cfg_pkg::WMASK_CLAMP, video_cfg_pkg::RST_CLAMP); // RL18
                video_cfg_pkg::OFF_SYNC_CTRL: syncCtrl_d = merge(regWrData,
                    video_cfg_pkg::WMASK_SYNC, video_cfg_pkg::RST_SYNC); // RL18
                video_cfg_pkg::OFF_REF_MULT: refMult_d = regWrData;
                video_cfg_pkg::OFF_PHASE: phaseReg_d = merge(regWrData,
                    video_cfg_pkg::WMASK_PHASE, video_cfg_pkg::RST_PHASE);
                default: ; // unmapped writes are dropped
            endcase
        end
    end

    // sync generation state
    logic [LINE_CNT_W-1:0] lineCnt_q, lineCnt_d;
    logic [LINE_CNT_W-1:0] lineLen_q, lineLen_d;
    logic [LINE_CNT_W-1:0] pulseLeft_q, pulseLeft_d;
    logic seenStrobe_q, seenStrobe_d;
    logic lineValid_q, lineValid_d;
    logic hPulse_q, hPulse_d;
    logic vsAligned_q, vsAligned_d;
    logic sepVert_q, sepVert_d;
    logic vertPulse_q, vertPulse_d;
    logic passthru_q, passthru_d;
    logic coast_q, coast_d;
    logic [NCO_W-1:0] ncoAcc_q, ncoAcc_d;
    logic [PW-1:0] phase_q, phase_d;
    logic leadLock;
    logic [video_cfg_pkg::NUM_CH-1:0] atTarget;

    assign leadLock = syncCtrl_q[video_cfg_pkg::SYNC_LEAD_LOCK_BIT];

    // line length is learnt between lock strobes so the trailing-locked
    // pulse can start early; the first line after reset gives no pulse
    always_comb begin
        coast_d = coastIn ^ syncCtrl_q[video_cfg_pkg::SYNC_COAST_POL_BIT]; // RL7
        lineCnt_d = lockEdgeStrobe ? '0
                  : (lineCnt_q == LINE_MAX) ? lineCnt_q : lineCnt_q + 1'b1;
        lineLen_d = lockEdgeStrobe ? LINE_CNT_W'(lineCnt_q + 1'b1) : lineLen_q;
        seenStrobe_d = seenStrobe_q || lockEdgeStrobe;
        lineValid_d = lineValid_q || (seenStrobe_q && lockEdgeStrobe);
        pulseLeft_d = pulseLeft_q;
        if (leadLock && lockEdgeStrobe) pulseLeft_d = WIDTH_C; // RL10
        else if (pulseLeft_q != '0) pulseLeft_d = pulseLeft_q - 1'b1;
        if (leadLock) hPulse_d = (pulseLeft_d != '0); // RL10
        else hPulse_d = lineValid_q && !lockEdgeStrobe && (lineLen_q > WIDTH_C)
                      && (lineCnt_d >= lineLen_q - WIDTH_C); // RL9
        vsAligned_d = (hPulse_d && !hPulse_q) ? rawVertSync : vsAligned_q; // RL11
        sepVert_d = syncCtrl_q[video_cfg_pkg::SYNC_VRAW_BIT] ? rawVertSync
                  : vsAligned_d; // RL11
        vertPulse_d = syncCtrl_q[video_cfg_pkg::SYNC_VCOAST_BIT] ? coast_d
                    : sepVert_d; // RL12
        passthru_d = horizSyncInput;
        // phase advances only on the crystal-derived clock, so no drift in a line
        ncoAcc_d = ncoAcc_q + ncoStep; // RL15
        phase_d = ncoAcc_d[NCO_W-1 -: PW] + phaseReg_q[PW-1:0]; // RL14
    end

    // read mux; data appear the cycle after the strobe
    always_comb begin
        rdData_d = '0;
        if (regRead) begin
            case (regAddr)
                video_cfg_pkg::OFF_MODE_CFG: rdData_d = modeCfg_q;
                video_cfg_pkg::OFF_RED_TGT: rdData_d = tgt_q[0];
                video_cfg_pkg::OFF_GREEN_TGT: rdData_d = tgt_q[1];
                video_cfg_pkg::OFF_BLUE_TGT: rdData_d = tgt_q[2];
                video_cfg_pkg::OFF_RED_DOFS: rdData_d = dofs_q[0];
                video_cfg_pkg::OFF_GREEN_DOFS: rdData_d = dofs_q[1];
                video_cfg_pkg::OFF_BLUE_DOFS: rdData_d = dofs_q[2];
                video_cfg_pkg::OFF_CLAMP: rdData_d = clamp_q;
                video_cfg_pkg::OFF_SYNC_CTRL: rdData_d = syncCtrl_q;
                video_cfg_pkg::OFF_REF_MULT: rdData_d = refMult_q;
                video_cfg_pkg::OFF_PHASE: rdData_d = phaseReg_q;
                video_cfg_pkg::OFF_STATUS: rdData_d = {2'b00, atTarget, sepVert_q,
                                                       hPulse_q, coast_q};
                default: rdData_d = '0; // unmapped reads return zero
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeCfg_q <= video_cfg_pkg::RST_MODE;
            for (int i = 0; i < video_cfg_pkg::NUM_CH; i++) begin
                tgt_q[i] <= video_cfg_pkg::RST_TARGET; // RL18
                dofs_q[i] <= video_cfg_pkg::RST_DOFS;
            end
            clamp_q <= video_cfg_pkg::RST_CLAMP; // RL5
            syncCtrl_q <= video_cfg_pkg::RST_SYNC; // RL6
            refMult_q <= video_cfg_pkg::RST_REF_MULT;
            phaseReg_q <= video_cfg_pkg::RST_PHASE;
            rdData_q <= '0;
            rdValid_q <= 1'b0;
        end else if (ce) begin
            modeCfg_q <= modeCfg_d;
            tgt_q <= tgt_d;
            dofs_q <= dofs_d;
            clamp_q <= clamp_d;
            syncCtrl_q <= syncCtrl_d;
            refMult_q <= refMult_d;
            phaseReg_q <= phaseReg_d;
            rdData_q <= rdData_d;
            rdValid_q <= regRead;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lineCnt_q <= '0;
            lineLen_q <= '0;
            pulseLeft_q <= '0;
            seenStrobe_q <= 1'b0;
            lineValid_q <= 1'b0;
            hPulse_q <= 1'b0;
            vsAligned_q <= 1'b0;
            sepVert_q <= 1'b0;
            vertPulse_q <= 1'b0;
            passthru_q <= 1'b0;
            coast_q <= 1'b0;
            ncoAcc_q <= '0;
            phase_q <= '0;
        end else if (ce) begin
            lineCnt_q <= lineCnt_d;
            lineLen_q <= lineLen_d;
            pulseLeft_q <= pulseLeft_d;
            seenStrobe_q <= seenStrobe_d;
            lineValid_q <= lineValid_d;
            hPulse_q <= hPulse_d;
            vsAligned_q <= vsAligned_d;
            sepVert_q <= sepVert_d;
            vertPulse_q <= vertPulse_d;
            passthru_q <= passthru_d;
            coast_q <= coast_d;
            ncoAcc_q <= ncoAcc_d;
            phase_q <= phase_d;
        end
    end

    // three channels share one servo design; green never takes the mid-scale base
    logic [7:0] sampleArr [video_cfg_pkg::NUM_CH];
    logic [7:0] levelArr [video_cfg_pkg::NUM_CH];
    logic [7:0] adjArr [video_cfg_pkg::NUM_CH];
    logic [video_cfg_pkg::NUM_CH-1:0] midSel;
    assign sampleArr[0] = redSample;
    assign sampleArr[1] = greenSample;
    assign sampleArr[2] = blueSample;
    assign ycbcrMode = modeCfg_q[video_cfg_pkg::MODE_YCBCR_BIT]; // RL17
    assign midSel = {ycbcrMode, 1'b0, ycbcrMode}; // RL1 RL2 RL3

    for (genvar c = 0; c < video_cfg_pkg::NUM_CH; c++) begin : g_ch
        channel_black_servo #(.W(8)) u_servo (
            .clk(clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .targetCode(tgt_q[c]),
            .midScale(midSel[c]),
            .digitalOffset(dofs_q[c]),
            .sample(sampleArr[c]),
            .backPorch(backPorch),
            .blackLevel_q(levelArr[c]),
            .servoUp_q(servoUp[c]),
            .servoDown_q(servoDown[c]),
            .adjustedSample_q(adjArr[c])
        );
        assign atTarget[c] = !servoUp[c] && !servoDown[c];
    end

    // outputs
    assign redBlackLevel = levelArr[0];
    assign greenBlackLevel = levelArr[1];
    assign blueBlackLevel = levelArr[2];
    assign redAdjusted = adjArr[0];
    assign greenAdjusted = adjArr[1];
    assign blueAdjusted = adjArr[2];
    assign clampSelect = clamp_q[video_cfg_pkg::CLAMP_SEL_MSB:video_cfg_pkg::CLAMP_SEL_LSB];
    assign clampEnable = (clampSelect != video_cfg_pkg::CLAMP_OFF); // RL5
    assign referenceMultiplier = refMult_q;
    assign samplePhase = phase_q;
    assign coastActive = coast_q;
    assign regRdData = rdValid_q ? rdData_q : '0;
    assign horizPulseOut = hPulse_q;
    assign vertPulseOut = vertPulse_q;
    assign horizSyncPassthruOut = passthru_q;
    assign separatedVertSyncOut = sepVert_q;
    // one bit releases all four pins together
    assign horizPulseOe = !syncCtrl_q[video_cfg_pkg::SYNC_TRISTATE_BIT]; // RL6
    assign vertPulseOe = horizPulseOe;
    assign horizSyncPassthruOe = horizPulseOe;
    assign separatedVertSyncOe = horizPulseOe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_sync_pin_release: assert property (ce && regWrite && regAddr == // RL6
        video_cfg_pkg::OFF_SYNC_CTRL && regWrData[video_cfg_pkg::SYNC_TRISTATE_BIT]
        |=> !horizPulseOe && !vertPulseOe && !horizSyncPassthruOe && !separatedVertSyncOe)
        else $error("sync pins still driven after release");
    a_coast_polarity: assert property (ce |=> coastActive == // RL7
        ($past(coastIn) ^ $past(syncCtrl_q[video_cfg_pkg::SYNC_COAST_POL_BIT])))
        else $error("coast polarity wrong");
    a_lead_edge_lock: assert property (ce && lockEdgeStrobe && leadLock // RL10
        |=> horizPulseOut)
        else $error("leading edge not on lock strobe");
    a_trail_edge_lock: assert property (ce && lockEdgeStrobe && !leadLock // RL9
        |=> !horizPulseOut)
        else $error("trailing edge not on lock strobe");
    a_clamp_reserved: assert property ((clamp_q & ~video_cfg_pkg::WMASK_CLAMP) == // RL18
        (video_cfg_pkg::RST_CLAMP & ~video_cfg_pkg::WMASK_CLAMP)
        && (syncCtrl_q & ~video_cfg_pkg::WMASK_SYNC) == '0)
        else $error("reserved bits changed");
    a_target_readback: assert property (ce && regRead && regAddr == // RL18
        video_cfg_pkg::OFF_RED_TGT |=> regRdData == $past(tgt_q[0]))
        else $error("red target read back wrong");
    a_coast_route: assert property (ce && syncCtrl_q[video_cfg_pkg::SYNC_VCOAST_BIT] // RL12
        |=> vertPulseOut == ($past(coastIn)
        ^ $past(syncCtrl_q[video_cfg_pkg::SYNC_COAST_POL_BIT])))
        else $error("coast not routed to vertical pin");
    a_red_mid_scale: assert property (ce && ycbcrMode && tgt_q[0] == '0 // RL1
        |=> redBlackLevel == video_cfg_pkg::MID_SCALE)
        else $error("red base not mid-scale");
    a_green_zero_base: assert property (ce && ycbcrMode && tgt_q[1] == '0 // RL2
        |=> greenBlackLevel == video_cfg_pkg::ZERO_CODE)
        else $error("green base shifted");
    a_raw_vert_mode: assert property (ce && syncCtrl_q[video_cfg_pkg::SYNC_VRAW_BIT] // RL11
        |=> separatedVertSyncOut == $past(rawVertSync))
        else $error("raw vertical not passed");

    c_lead_pulse: cover property (ce && lockEdgeStrobe && leadLock ##1 horizPulseOut[*2]);
    c_trail_pulse: cover property (!leadLock && !horizPulseOut ##1 horizPulseOut);
    c_pins_released: cover property (!horizPulseOe);
    c_coast_on_vert: cover property (syncCtrl_q[video_cfg_pkg::SYNC_VCOAST_BIT] && vertPulseOut);
endmodule : black_level_target_sync_output_ctrl
`default_nettype wire

// ---- sim/sync_receiver.sv ----
// downstream processor model that resolves the four sync lines it receives
`timescale 1ns/100ps
`default_nettype none
module sync_receiver (
    input wire logic clk,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    output var logic [3:0] lineLevel
);
    logic [3:0] last_q;
    logic [3:0] last_d;
    // no keeper on these lines: a released line shows the inverse of its last level
    always_comb begin
        last_d = (pinOe & pinOut) | (~pinOe & last_q);
        lineLevel = (pinOe & pinOut) | (~pinOe & ~last_q);
    end
    always_ff @(posedge clk) begin
        last_q <= last_d;
    end
endmodule : sync_receiver
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the black-level target and sync output register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin numErrors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    logic clk, sys_rst, ce, regWrite, regRead, backPorch, lockEdgeStrobe, a, b;
    logic horizSyncInput, rawVertSync, coastIn, coastActive, clampEnable, ycbcrMode;
    logic horizPulseOut, horizPulseOe, vertPulseOut, vertPulseOe, horizSyncPassthruOut;
    logic horizSyncPassthruOe, separatedVertSyncOut, separatedVertSyncOe;
    logic [7:0] regAddr, regWrData, regRdData, redSample, greenSample, blueSample, d, s, n;
    logic [7:0] redBlackLevel, greenBlackLevel, blueBlackLevel, redAdjusted, greenAdjusted;
    logic [7:0] blueAdjusted, referenceMultiplier;
    logic [2:0] servoUp, servoDown, clampSelect;
    logic [23:0] ncoStep;
    logic [5:0] samplePhase, p;
    logic [3:0] lineLevel, oeAll;
    int numErrors = 0;
    int checked = 0;
    logic [7:0] offs [6] = '{8'h1d, 8'h1e, 8'h1f, 8'h23, 8'h25, 8'h2b};
    logic [7:0] rsv [6] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h14};
    logic [7:0] msk [6] = '{8'hff, 8'hff, 8'hff, 8'h70, 8'h97, 8'hff};
    assign oeAll = {vertPulseOe, horizPulseOe, separatedVertSyncOe, horizSyncPassthruOe};
    black_level_target_sync_output_ctrl #(.HPULSE_WIDTH(16)) u_black_level_target_sync_output_ctrl (
        .clk, .sys_rst, .ce, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .redSample,
        .greenSample, .blueSample, .backPorch, .redBlackLevel, .greenBlackLevel, .blueBlackLevel,
        .redAdjusted, .greenAdjusted, .blueAdjusted, .servoUp, .servoDown, .clampSelect,
        .clampEnable, .ycbcrMode, .lockEdgeStrobe, .horizSyncInput, .rawVertSync, .coastIn,
        .coastActive, .horizPulseOut, .horizPulseOe, .vertPulseOut, .vertPulseOe,
        .horizSyncPassthruOut, .horizSyncPassthruOe, .separatedVertSyncOut,
        .separatedVertSyncOe, .referenceMultiplier, .ncoStep, .samplePhase);
    sync_receiver u_sync_receiver (.clk, .pinOe(oeAll), .lineLevel, .pinOut({vertPulseOut,
        horizPulseOut, separatedVertSyncOut, horizSyncPassthruOut}));
    function automatic logic [7:0] clip(input int x);
        return (x < 0) ? 8'h00 : (x > 255) ? 8'hff : x[7:0];
    endfunction : clip
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= ad;
        regWrData <= dt;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= ad;
        @(posedge clk);
        regRead <= 1'b0;
        #1 `CHK(regRdData, e)
    endtask : rchk
    // one 40-cycle line: pulse level in the strobe cycle, the next one, and high count
    task automatic line;
        @(posedge clk);
        lockEdgeStrobe <= 1'b1;
        #1 a = horizPulseOut;
        @(posedge clk);
        lockEdgeStrobe <= 1'b0;
        #1 b = horizPulseOut;
        n = 8'(a + b);
        repeat (38) begin
            @(posedge clk);
            #1 n += horizPulseOut;
        end
    endtask : line
    task automatic finish_test;
        $display("errors %0d comparisons %0d", numErrors, checked);
        if (numErrors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // a hang costs a mismatch; the tests need about 500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        finish_test;
    end
    initial begin
        {sys_rst, ce, regWrite, regRead, backPorch, lockEdgeStrobe} = 6'h30;
        {horizSyncInput, rawVertSync, coastIn, regAddr, regWrData, ncoStep} = '0;
        {redSample, greenSample, blueSample} = '0;
        void'($urandom(32'h1282b2a3));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rchk(offs[i], rsv[i]);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(offs[i], d);
            rchk(offs[i], (d & msk[i]) | (rsv[i] & ~msk[i]));
        end
        wr(8'h40, 8'h5a);
        rchk(8'h40, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(video_cfg_pkg::OFF_MODE_CFG, {5'h00, m[0], 2'h0});
            for (int k = 0; k < 5; k++) begin
                d = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : (k == 2) ? 8'h00 : 8'($urandom);
                for (int c = 0; c < 3; c++) wr(offs[c], d);
                tick(2);
                `CHK(redBlackLevel, clip(m * 128 + $signed(d)))
                `CHK(greenBlackLevel, clip($signed(d)))
                `CHK(blueBlackLevel, clip(m * 128 + $signed(d)))
            end
            `CHK(ycbcrMode, m[0])
        end
        wr(offs[0], 8'h10);
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 8'h80 : 8'($urandom);
            s = (k == 1) ? 8'hff : 8'($urandom);
            wr(video_cfg_pkg::OFF_RED_DOFS, d);
            redSample <= s;
            greenSample <= s;
            backPorch <= 1'($urandom);
            tick(2);
            `CHK(redAdjusted, clip(int'(s) + $signed(d)))
            `CHK(redBlackLevel, 8'h90)
            `CHK({greenAdjusted, blueAdjusted}, {s, 8'h00})
            `CHK({servoUp[0], servoDown[0]}, {backPorch && s < 8'h90, backPorch && s > 8'h90})
        end
        for (int c = 0; c < 8; c++) begin
            wr(offs[3], {1'b1, c[2:0], 4'h0});
            rchk(offs[3], {1'b0, c[2:0], 4'h8});
            `CHK(clampSelect, c[2:0])
            `CHK(clampEnable, c != 0)
        end
        for (int k = 0; k < 4; k++) begin
            wr(offs[4], {1'b1, 5'h00, k[0], k[1]});
            coastIn <= 1'($urandom);
            tick(3);
            `CHK(coastActive, coastIn ^ k[0])
            `CHK(vertPulseOut, coastIn ^ k[0])
            `CHK(oeAll, {4{~k[1]}})
        end
        wr(offs[4], 8'h00);
        repeat (3) line;
        `CHK({a, b, n}, {2'b10, 8'd16})
        wr(offs[4], 8'h04);
        rawVertSync <= 1'b1;
        repeat (2) line;
        `CHK({a, b, n}, {2'b01, 8'd16})
        rawVertSync <= 1'b0;
        tick(3);
        `CHK(separatedVertSyncOut, 1'b1)
        `CHK(lineLevel[2], horizPulseOut)
        wr(offs[4], 8'h10);
        for (int k = 0; k < 4; k++) begin
            rawVertSync <= k[0];
            horizSyncInput <= ~k[0];
            tick(2);
            `CHK({separatedVertSyncOut, horizSyncPassthruOut}, {k[0], ~k[0]})
            @(posedge clk);
        end
        wr(video_cfg_pkg::OFF_PHASE, 8'hff);
        rchk(video_cfg_pkg::OFF_PHASE, 8'h3f);
        ncoStep <= 24'h040000;
        tick(2);
        repeat (70) begin
            p = samplePhase;
            tick(1);
            `CHK(samplePhase, p + 6'h01)
        end
        wr(offs[5], 8'h1c);
        tick(1);
        `CHK(referenceMultiplier, 8'h1c)
        ce <= 1'b0;
        wr(offs[5], 8'h55);
        ce <= 1'b1;
        rchk(offs[5], 8'h1c);
        finish_test;
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
